// ==== rtl/pin_sync.sv ====
module pin_sync #(
    parameter int WIDTH = 9
) (
    input  wire logic             sys_clk_in,
    input  wire logic             resetn_in,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out,
    output logic      [WIDTH-1:0] rise_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync2_ff;
    logic [WIDTH-1:0] sync3_ff;
    logic [WIDTH-1:0] level_ff;
    logic [WIDTH-1:0] rise_ff;
    wire  [WIDTH-1:0] agree_w;
    wire  [WIDTH-1:0] nxt_level;
    wire  [WIDTH-1:0] nxt_rise;

    // A change is accepted only once the second and third stages agree.
    assign agree_w   = ~(sync2_ff ^ sync3_ff);
    assign nxt_level = (agree_w & sync3_ff) | (~agree_w & level_ff);
    assign nxt_rise  = nxt_level & ~level_ff;

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta_ff  <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
            level_ff <= '0;
            rise_ff  <= '0;
        end else begin
            meta_ff  <= pin_in;
            sync2_ff <= meta_ff;
            sync3_ff <= sync2_ff;
            level_ff <= nxt_level;
            rise_ff  <= nxt_rise;
        end
    end

    assign level_out = level_ff;
    assign rise_out  = rise_ff;

endmodule : pin_sync

// ==== rtl/vme_irq_enable_status.sv ====
// Summary of operation
// - Enable bit of soft level 7..1 going zero to one raises that VME level.
// - Clearing a soft level enable masks it; its status bit stays.
// - General soft enable going zero to one asserts the general soft request.
// - Clearing the general soft enable masks it and drops its VME line.
// - That clear leaves the general soft status set until software clears it.
// - Auto-config strap sets the general soft enable after reset.
// - VME bus error enable forwards the error source when one, blocks when zero.
// - PCI bus error enable forwards the error source when one, blocks when zero.
// - DMA enable forwards DMA completion when one, blocks when zero.
// - Mailbox and local PCI input enables pass or mask their sources.
// - All other enable bits are not implemented: writes to them are dropped and they read zero.
// - Status bits read one while active; cleared only by writing one.
// - Three-bit level code routes a source; 001 is level one, 000 masks.
// - Auto-config strap resets the general soft level code to 010.
`include "vme_irq_regs.svh"

module vme_irq_enable_status (
    input  wire logic                sys_clk_in,
    input  wire logic                resetn_in,
    input  wire vme_irq_pkg::addr_t  addr_in,
    input  wire vme_irq_pkg::word_t  wdata_in,
    input  wire logic                wr_in,
    input  wire logic                rd_in,
    output vme_irq_pkg::word_t       rdata_out,
    input  wire logic [3:0]          mailbox_event_in,
    input  wire logic                vme_bus_error_in,
    input  wire logic                pci_bus_error_in,
    input  wire logic                dma_done_in,
    input  wire logic [7:0]          local_pci_irq_inputs_in,
    input  wire logic                auto_config_powerup_option_in,
    output vme_irq_pkg::level_vec_t  vme_irq_req_out,
    output logic                     irq_out
);

    import vme_irq_pkg::*;

    // Level code to one-hot request lines; code zero has no line.
    function automatic level_vec_t level_decode(input level_code_t code,
                                                input logic        active);
        level_vec_t vec;
        vec = '0;
        for (int k = 1; k <= 7; k++) begin
            if (active && code == level_code_t'(k)) begin
                vec[k] = 1'b1;
            end
        end
        return vec;
    endfunction : level_decode

    // Address decode shared by the read and write paths.
    function automatic logic hit(input addr_t addr, input addr_t ofs);
        return addr == ofs;
    endfunction : hit

    init_state_e state_ff;
    init_state_e nxt_state;
    logic [2:0]  settle_ff;
    logic [2:0]  nxt_settle;
    word_t       enable_ff;
    word_t       status_ff;
    word_t       map_local_ff;
    word_t       map_misc_ff;
    word_t       map_mbox_ff;
    word_t       local_mask_ff;
    word_t       rdata_ff;
    level_vec_t  req_ff;
    logic        irq_ff;

    word_t       nxt_enable;
    word_t       nxt_status;
    word_t       nxt_map_local;
    word_t       nxt_map_misc;
    word_t       nxt_map_mbox;
    word_t       nxt_local_mask;
    word_t       nxt_rdata;
    level_vec_t  nxt_req;
    logic        nxt_irq;

    wire  [8:0]  pin_level_w;
    wire  [8:0]  pin_rise_w;
    wire         strap_w;
    wire         load_w;
    wire         wr_enable_w;
    wire         wr_status_w;
    wire         wr_map_local_w;
    wire         wr_map_misc_w;
    wire         wr_map_mbox_w;
    wire         wr_local_mask_w;
    word_t       soft_edge_w;
    word_t       hw_event_w;
    word_t       set_w;
    word_t       clear_w;
    word_t       active_w;
    word_t       enable_wr_val_w;
    word_t       map_misc_wr_val_w;
    word_t       strap_set_w;
    word_t       rd_sel_w;
    level_code_t code_w [32];
    level_vec_t  contrib_w [32];

    // The local PCI inputs and the strap come from pins.
    pin_sync #(
        .WIDTH (9)
    ) u_pin_sync (
        .sys_clk_in (sys_clk_in),
        .resetn_in  (resetn_in),
        .pin_in     ({auto_config_powerup_option_in, local_pci_irq_inputs_in}),
        .level_out  (pin_level_w),
        .rise_out   (pin_rise_w)
    );

    assign strap_w = pin_level_w[8];

    // The strap is caught only after it has passed the synchroniser, since an
    // asynchronous reset may not load a pin value.
    assign nxt_settle = (state_ff == ST_SETTLE) ? settle_ff + 3'h1 : settle_ff;
    always_comb begin
        case (state_ff)
            ST_SETTLE: nxt_state = (settle_ff == `STRAP_SETTLE_CYCLES) ? ST_LOAD : ST_SETTLE;
            ST_LOAD:   nxt_state = ST_RUN;
            ST_RUN:    nxt_state = ST_RUN;
            default:   nxt_state = ST_SETTLE;
        endcase
    end
    assign load_w = (state_ff == ST_LOAD);

    assign wr_enable_w     = wr_in && hit(addr_in, `VME_IRQ_ENABLE_OFS);
    assign wr_status_w     = wr_in && hit(addr_in, `VME_IRQ_STATUS_OFS);
    assign wr_map_local_w  = wr_in && hit(addr_in, `VME_LEVEL_MAP_LOCAL_OFS);
    assign wr_map_misc_w   = wr_in && hit(addr_in, `VME_LEVEL_MAP_MISC_OFS);
    assign wr_map_mbox_w   = wr_in && hit(addr_in, `VME_LEVEL_MAP_MBOX_OFS);
    assign wr_local_mask_w = wr_in && hit(addr_in, `LOCAL_IRQ_MASK_OFS);

    // Software interrupts fire on a zero-to-one write of their enable bit.
    assign soft_edge_w = wr_enable_w ? (wdata_in & ~enable_ff & `IRQ_SOFT_EDGE_MASK)
                                     : `WORD_RESET;

    assign hw_event_w = {12'h000, mailbox_event_in, 5'h00, vme_bus_error_in,
                         pci_bus_error_in, dma_done_in, pin_rise_w[7:0]};

    assign set_w   = (soft_edge_w | hw_event_w) & `IRQ_VALID_MASK;
    assign clear_w = wr_status_w ? wdata_in : `WORD_RESET;

    // A set in the same cycle as a clear wins, so no event is lost.
    assign nxt_status = (status_ff & ~clear_w) | set_w | strap_set_w;

    // The strap is ORed in rather than selected, so that a write or an event that
    // falls in the load cycle is not lost.
    assign strap_set_w = word_t'(load_w && strap_w) << `GENERAL_SOFT_POS;

    assign enable_wr_val_w = wr_enable_w ? (wdata_in & `IRQ_VALID_MASK)
                                         : enable_ff;
    assign nxt_enable = enable_wr_val_w | strap_set_w;

    assign nxt_map_local = wr_map_local_w ? (wdata_in & `MAP_LOCAL_VALID_MASK) : map_local_ff;
    assign map_misc_wr_val_w = wr_map_misc_w ? (wdata_in & `MAP_MISC_VALID_MASK)
                                             : map_misc_ff;
    assign nxt_map_misc = (load_w && strap_w)
                        ? (map_misc_wr_val_w | (word_t'(`GENERAL_SOFT_AUTO_LEVEL)
                                                << `MAP_GENERAL_SOFT_LO))
                        : map_misc_wr_val_w;
    assign nxt_map_mbox   = wr_map_mbox_w ? (wdata_in & `MAP_MBOX_VALID_MASK) : map_mbox_ff;
    assign nxt_local_mask = wr_local_mask_w ? (wdata_in & `IRQ_VALID_MASK) : local_mask_ff;

    // A source drives its line only while both its status and enable are set.
    assign active_w = status_ff & enable_ff & `IRQ_VALID_MASK;

    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_route
            if (gi >= `SOFT_LEVEL1_POS) begin : g_soft
                assign code_w[gi] = level_code_t'(gi - `SOFT_LEVEL1_POS + 1);
            end else if (gi >= `MBOX_LO_POS && gi <= `MBOX_HI_POS) begin : g_mbox
                assign code_w[gi] = map_mbox_ff[(gi - `MBOX_LO_POS) * `MAP_FIELD_STRIDE +: 3];
            end else if (gi == `GENERAL_SOFT_POS) begin : g_gen
                assign code_w[gi] = map_misc_ff[`MAP_GENERAL_SOFT_LO +: 3];
            end else if (gi == `VME_ERR_POS) begin : g_vme_bus_error_irq
                assign code_w[gi] = map_misc_ff[`MAP_VME_ERR_LO +: 3];
            end else if (gi == `PCI_ERR_POS) begin : g_pci_bus_error_irq
                assign code_w[gi] = map_misc_ff[`MAP_PCI_ERR_LO +: 3];
            end else if (gi == `DMA_POS) begin : g_dma
                assign code_w[gi] = map_misc_ff[`MAP_DMA_LO +: 3];
            end else if (gi < `DMA_POS) begin : g_local
                assign code_w[gi] = map_local_ff[gi * `MAP_FIELD_STRIDE +: 3];
            end else begin : g_none
                assign code_w[gi] = `LEVEL_CODE_MASKED;
            end
            assign contrib_w[gi] = level_decode(code_w[gi], active_w[gi]);
        end
    endgenerate

    always_comb begin
        nxt_req = '0;
        for (int i = 0; i < 32; i++) begin
            nxt_req = nxt_req | contrib_w[i];
        end
    end

    assign nxt_irq = |(status_ff & local_mask_ff);

    // Unmapped reads return zero; the data stand only in the cycle after the strobe.
    assign rd_sel_w =
        hit(addr_in, `VME_IRQ_ENABLE_OFS)      ? enable_ff     :
        hit(addr_in, `VME_IRQ_STATUS_OFS)      ? status_ff     :
        hit(addr_in, `VME_LEVEL_MAP_LOCAL_OFS) ? map_local_ff  :
        hit(addr_in, `VME_LEVEL_MAP_MISC_OFS)  ? map_misc_ff   :
        hit(addr_in, `VME_LEVEL_MAP_MBOX_OFS)  ? map_mbox_ff   :
        hit(addr_in, `LOCAL_IRQ_MASK_OFS)      ? local_mask_ff :
                                                 `WORD_RESET;
    assign nxt_rdata = rd_in ? rd_sel_w : `WORD_RESET;

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_ff  <= ST_SETTLE;
            settle_ff <= 3'h0;
        end else begin
            state_ff  <= nxt_state;
            settle_ff <= nxt_settle;
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            enable_ff     <= `WORD_RESET;
            status_ff     <= `WORD_RESET;
            map_local_ff  <= `WORD_RESET;
            map_misc_ff   <= `WORD_RESET;
            map_mbox_ff   <= `WORD_RESET;
            local_mask_ff <= `WORD_RESET;
        end else begin
            enable_ff     <= nxt_enable;
            status_ff     <= nxt_status;
            map_local_ff  <= nxt_map_local;
            map_misc_ff   <= nxt_map_misc;
            map_mbox_ff   <= nxt_map_mbox;
            local_mask_ff <= nxt_local_mask;
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_ff <= `WORD_RESET;
            req_ff   <= '0;
            irq_ff   <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            req_ff   <= nxt_req;
            irq_ff   <= nxt_irq;
        end
    end

    assign rdata_out       = rdata_ff;
    assign vme_irq_req_out = req_ff;
    assign irq_out         = irq_ff;

endmodule : vme_irq_enable_status

// ==== rtl/vme_irq_pkg.sv ====
package vme_irq_pkg;

    typedef logic [31:0] word_t;
    typedef logic [11:0] addr_t;
    typedef logic [2:0]  level_code_t;
    typedef logic [7:1]  level_vec_t;

    typedef enum logic [2:0] {
        ST_SETTLE = 3'b001,
        ST_LOAD   = 3'b010,
        ST_RUN    = 3'b100
    } init_state_e;

endpackage : vme_irq_pkg

// ==== rtl/vme_irq_regs.svh ====
`ifndef VME_IRQ_REGS_SVH
`define VME_IRQ_REGS_SVH

// Register byte offsets on the local register port.
`define VME_IRQ_ENABLE_OFS      12'h310
`define VME_IRQ_STATUS_OFS      12'h314
`define VME_LEVEL_MAP_LOCAL_OFS 12'h318
`define VME_LEVEL_MAP_MISC_OFS  12'h31C
`define VME_LEVEL_MAP_MBOX_OFS  12'h340
`define LOCAL_IRQ_MASK_OFS      12'h344

// Implemented bits of the enable, status and local mask registers.
`define IRQ_VALID_MASK          32'hFE0F17FF
`define IRQ_SOFT_EDGE_MASK      32'hFE001000
`define MAP_LOCAL_VALID_MASK    32'h77777777
`define MAP_MISC_VALID_MASK     32'h00070777
`define MAP_MBOX_VALID_MASK     32'h00007777

// Field positions.
`define SOFT_LEVEL1_POS         25
`define SOFT_LEVEL7_POS         31
`define MBOX_LO_POS             16
`define MBOX_HI_POS             19
`define GENERAL_SOFT_POS        12
`define VME_ERR_POS             10
`define PCI_ERR_POS             9
`define DMA_POS                 8
`define MAP_GENERAL_SOFT_LO     16
`define MAP_VME_ERR_LO          8
`define MAP_PCI_ERR_LO          4
`define MAP_DMA_LO              0
`define MAP_FIELD_STRIDE        4

// Reset values.
`define WORD_RESET              32'h00000000
`define GENERAL_SOFT_AUTO_LEVEL 3'h2
`define LEVEL_CODE_MASKED       3'h0

// Cycles the strap input is left to settle through the pin synchroniser.
`define STRAP_SETTLE_CYCLES     3'h4

`endif

// ==== verif/vme_irq_enable_status_asserts.sv ====
`include "vme_irq_regs.svh"

module vme_irq_enable_status_asserts
    import vme_irq_pkg::*;
(
    input wire logic                    sys_clk_in,
    input wire logic                    resetn_in,
    input wire vme_irq_pkg::addr_t      addr_in,
    input wire vme_irq_pkg::word_t      wdata_in,
    input wire logic                    wr_in,
    input wire logic                    rd_in,
    input wire vme_irq_pkg::word_t      rdata_out,
    input wire logic                    auto_config_powerup_option_in,
    input wire vme_irq_pkg::level_vec_t vme_irq_req_out,
    input wire logic                    irq_out
);
    timeunit 1ns;
    timeprecision 100ps;
    import vme_irq_pkg::*;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);

    word_t      en_sh_ff;
    level_vec_t rise_ff;
    logic [3:0] cnt_ff;
    wire logic  en_wr  = wr_in && addr_in == `VME_IRQ_ENABLE_OFS;
    wire logic  quiet  = !auto_config_powerup_option_in;
    wire logic  mapped = addr_in inside {12'h310, 12'h314, 12'h318, 12'h31C, 12'h340, 12'h344};
    wire level_vec_t fresh = wdata_in[31:25] & ~en_sh_ff[31:25];

    // The shadow is only trusted with the strap low, since the strap may set bit 12 on its own.
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            en_sh_ff <= `WORD_RESET;
            rise_ff  <= 7'h00;
            cnt_ff   <= 4'h0;
        end else begin
            if (en_wr) begin
                en_sh_ff <= wdata_in & `IRQ_VALID_MASK;
                rise_ff  <= fresh;
            end
            if (cnt_ff != 4'hF) begin
                cnt_ff <= cnt_ff + 4'h1;
            end
        end
    end

    property p_soft_raise;
        en_wr && |fresh |-> ##[1:2] (vme_irq_req_out & rise_ff) == rise_ff;
    endproperty
    property p_all_masked;
        en_wr && wdata_in == 32'h0 |-> ##2 vme_irq_req_out == 7'h00;
    endproperty
    property p_quiet;
        (quiet && en_sh_ff == 32'h0) [*3] |-> vme_irq_req_out == 7'h00;
    endproperty
    property p_irq_masked;
        wr_in && addr_in == `LOCAL_IRQ_MASK_OFS && wdata_in == 32'h0 |-> ##2 !irq_out;
    endproperty
    property p_rdata_idle;
        !rd_in |=> rdata_out == 32'h0;
    endproperty
    property p_unmapped;
        rd_in && !mapped |=> rdata_out == 32'h0;
    endproperty
    property p_read_enable;
        rd_in && addr_in == `VME_IRQ_ENABLE_OFS && quiet |=> rdata_out == $past(en_sh_ff);
    endproperty
    property p_strap;
        cnt_ff == 4'hA && !quiet |-> vme_irq_req_out == 7'h02;
    endproperty

    a_soft_raise:  assert property (p_soft_raise) else $error("soft level not raised");
    a_all_masked:  assert property (p_all_masked) else $error("request after mask");
    a_quiet:       assert property (p_quiet) else $error("request with no enable");
    a_irq_masked:  assert property (p_irq_masked) else $error("irq after mask");
    a_rdata_idle:  assert property (p_rdata_idle) else $error("read data not idle");
    a_unmapped:    assert property (p_unmapped) else $error("unmapped read nonzero");
    a_read_enable: assert property (p_read_enable) else $error("enable readback");
    a_strap:       assert property (p_strap) else $error("strap level wrong");

    c_soft:   cover property (p_soft_raise);
    c_masked: cover property (p_irq_masked);
    c_irq:    cover property (irq_out);
endmodule : vme_irq_enable_status_asserts

bind vme_irq_enable_status vme_irq_enable_status_asserts chk (
    .sys_clk_in                    (sys_clk_in),
    .resetn_in                     (resetn_in),
    .addr_in                       (addr_in),
    .wdata_in                      (wdata_in),
    .wr_in                         (wr_in),
    .rd_in                         (rd_in),
    .rdata_out                     (rdata_out),
    .auto_config_powerup_option_in (auto_config_powerup_option_in),
    .vme_irq_req_out               (vme_irq_req_out),
    .irq_out                       (irq_out)
);

// ==== verif/vme_irq_enable_status_tb_top.sv ====
`include "vme_irq_regs.svh"

module vme_irq_enable_status_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import vme_irq_pkg::*;

    localparam addr_t EN = `VME_IRQ_ENABLE_OFS;
    localparam addr_t ST = `VME_IRQ_STATUS_OFS;
    localparam addr_t MISC = `VME_LEVEL_MAP_MISC_OFS;
    logic        sys_clk_in = 1'h0;
    logic        resetn_in  = 1'h0;
    addr_t       addr_in    = 12'h000;
    word_t       wdata_in   = 32'h0;
    logic        wr_in      = 1'h0;
    logic        rd_in      = 1'h0;
    logic        strap      = 1'h1;
    word_t       ev         = 32'h0;
    word_t       rdata;
    level_vec_t  req;
    logic        irq;
    level_code_t top_level;
    int          n_mismatch = 0;
    int          tests_run  = 0;
    int          cycles     = 0;
    int          srcs[15]   = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 16, 17, 18, 19};

    vme_irq_enable_status uut (
        .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata),
        .mailbox_event_in(ev[19:16]), .vme_bus_error_in(ev[10]), .pci_bus_error_in(ev[9]),
        .dma_done_in(ev[8]), .local_pci_irq_inputs_in(ev[7:0]),
        .auto_config_powerup_option_in(strap), .vme_irq_req_out(req), .irq_out(irq));
    vme_irq_handler_model hdl (
        .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .req_in(req), .level_out(top_level));

    always #2.5 sys_clk_in = ~sys_clk_in;

    task automatic complete_run;
        if (n_mismatch == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run

    // The timeout sits far above the few hundred cycles the sequence needs.
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic check(input string what, input word_t exp, input word_t seen);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic check_req(input level_vec_t e);
        check("req", {25'h0, e}, {25'h0, req});
    endtask : check_req

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask : idle

    task automatic wr(input addr_t a, input word_t d);
        @(posedge sys_clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'h1;
        @(posedge sys_clk_in);
        wr_in    <= 1'h0;
    endtask : wr

    task automatic rd(input addr_t a, input word_t exp, input string what);
        @(posedge sys_clk_in);
        addr_in <= a;
        rd_in   <= 1'h1;
        @(posedge sys_clk_in);
        rd_in   <= 1'h0;
        #1;
        check(what, exp, rdata);
    endtask : rd

    task automatic do_reset(input logic s);
        @(posedge sys_clk_in);
        resetn_in <= 1'h0;
        strap     <= s;
        repeat (16) @(posedge sys_clk_in);
        resetn_in <= 1'h1;
        idle(12);
    endtask : do_reset

    // Local pins pass a synchroniser, so they are held for several cycles.
    task automatic fire(input int b);
        @(posedge sys_clk_in);
        ev <= 32'h1 << b;
        @(posedge sys_clk_in);
        ev <= ev & 32'h000000FF;
        repeat (3) @(posedge sys_clk_in);
        ev <= 32'h0;
        idle(8);
    endtask : fire

    function automatic level_vec_t lvl(input int b);
        int k;
        k = (b < 8) ? ((b == 7) ? 7 : b + 1) : (b < 16) ? b - 7 : b - 12;
        return level_vec_t'(7'h01 << (k - 1));
    endfunction : lvl

    initial begin
        do_reset(1'h1);
        check_req(7'h02);
        check("handler", 32'h2, {29'h0, top_level});
        rd(EN, 32'h00001000, "enable");
        rd(MISC, 32'h00020000, "misc map");
        wr(EN, 32'h0);
        idle(3);
        check_req(7'h00);
        rd(ST, 32'h00001000, "status");
        wr(ST, 32'h00001000);
        rd(ST, 32'h0, "status");
        do_reset(1'h0);
        rd(EN, 32'h0, "enable");
        rd(ST, 32'h0, "status");
        wr(EN, 32'hFFFFFFFF);
        rd(EN, `IRQ_VALID_MASK, "enable");
        wr(EN, 32'h0);
        wr(ST, 32'hFFFFFFFF);
        wr(12'h300, 32'hFFFFFFFF);
        rd(12'h300, 32'h0, "unmapped");
        rd(ST, 32'h0, "status");
        for (int k = 1; k <= 7; k++) begin
            wr(EN, 32'h1 << (24 + k));
            idle(3);
            check_req(lvl(k - 1));
            check("handler", word_t'(k), {29'h0, top_level});
            wr(EN, 32'h0);
            idle(3);
            check_req(7'h00);
            wr(ST, 32'h0);
            rd(ST, 32'h1 << (24 + k), "status");
            wr(ST, 32'h1 << (24 + k));
            rd(ST, 32'h0, "status");
        end
        wr(MISC, 32'h00050000);
        wr(EN, 32'h00001000);
        idle(3);
        check_req(7'h10);
        wr(EN, 32'h0);
        idle(3);
        check_req(7'h00);
        rd(ST, 32'h00001000, "status");
        wr(ST, 32'h00001000);
        wr(`VME_LEVEL_MAP_LOCAL_OFS, 32'h77654321);
        wr(MISC, 32'h00000321);
        wr(`VME_LEVEL_MAP_MBOX_OFS, 32'h00007654);
        wr(`LOCAL_IRQ_MASK_OFS, `IRQ_VALID_MASK);
        foreach (srcs[i]) begin
            fire(srcs[i]);
            rd(ST, 32'h1 << srcs[i], "status");
            check_req(7'h00);
            check("irq", 32'h1, {31'h0, irq});
            wr(EN, 32'h1 << srcs[i]);
            idle(3);
            check_req(lvl(srcs[i]));
            wr(ST, 32'h1 << srcs[i]);
            idle(3);
            check_req(7'h00);
            check("irq", 32'h0, {31'h0, irq});
        end
        wr(EN, 32'h00000100);
        wr(MISC, 32'h0);
        fire(8);
        check_req(7'h00);
        wr(`LOCAL_IRQ_MASK_OFS, 32'h0);
        idle(3);
        check("irq", 32'h0, {31'h0, irq});
        wr(MISC, 32'h00000001);
        idle(3);
        check_req(7'h01);
        complete_run();
    end
endmodule : vme_irq_enable_status_tb_top

// ==== verif/vme_irq_handler_model.sv ====
module vme_irq_handler_model
    import vme_irq_pkg::*;
(
    input  wire logic                    sys_clk_in,
    input  wire logic                    resetn_in,
    input  wire vme_irq_pkg::level_vec_t req_in,
    output vme_irq_pkg::level_code_t     level_out
);
    timeunit 1ns;
    timeprecision 100ps;
    import vme_irq_pkg::*;

    level_code_t level_ff;

    // The handler always serves the highest pending level first, as a backplane handler does.
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            level_ff <= 3'h0;
        end else begin
            level_ff <= 3'h0;
            for (int k = 1; k <= 7; k++) begin
                if (req_in[k]) begin
                    level_ff <= k[2:0];
                end
            end
        end
    end

    assign level_out = level_ff;
endmodule : vme_irq_handler_model
